// ==== tmc_timer.sv ====
`timescale 1ns/1ps
module tmc_timer (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  output logic             irq,
  output logic             chan_a_out,
  output logic             chan_a_connect,
  output logic             chan_b_out,
  output logic             chan_b_connect
);

  tmc_pkg::tmc_aphase_s ap_reg;
  tmc_pkg::tmc_aphase_s ap_next;
  logic                 rd_wait_reg;
  logic                 rd_wait_next;
  logic                 ready_reg;
  logic                 ready_next;
  logic [31:0]          rdata_reg;
  logic [31:0]          rdata_next;
  logic [7:0]           ctrl_a_reg;
  logic [7:0]           ctrl_a_next;
  logic [7:0]           ctrl_b_reg;
  logic [7:0]           ctrl_b_next;
  logic [7:0]           cmp_a_buf_reg;
  logic [7:0]           cmp_a_buf_next;
  logic [7:0]           cmp_b_buf_reg;
  logic [7:0]           cmp_b_buf_next;
  logic [7:0]           cmp_a_act_reg;
  logic [7:0]           cmp_a_act_next;
  logic [7:0]           cmp_b_act_reg;
  logic [7:0]           cmp_b_act_next;
  logic [2:0]           status_reg;
  logic [2:0]           status_next;
  logic [2:0]           mask_reg;
  logic [2:0]           mask_next;
  logic                 irq_reg;
  logic                 irq_next;
  logic [7:0]           cnt;
  logic                 up;
  logic                 run;
  logic                 high_bit;
  tmc_pkg::tmc_mode_e   mode;
  logic [7:0]           top;
  logic                 wr_a;
  logic                 wr_b;
  logic                 wr_ca;
  logic                 wr_cb;
  logic                 wr_st;
  logic                 wr_mk;
  logic                 dbl_buf;
  logic                 upd_evt;
  logic                 ovf_evt;
  logic [2:0]           set_evt;

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  always_comb
  begin
    high_bit = ctrl_b_reg[tmc_pkg::HB_POS];
    run      = ctrl_b_reg[tmc_pkg::RUN_POS];
    // three-bit waveform mode
    mode = tmc_pkg::tmc_mode_e'({high_bit,
             ctrl_a_reg[tmc_pkg::MODE_LO_POS +: 2]});
    // top source per mode
    top     = tmc_pkg::f_top(mode, cmp_a_act_reg);
    dbl_buf = tmc_pkg::f_is_pc(mode) || tmc_pkg::f_is_fast(mode);
    // pc: at top; fast: at the top-to-bottom step
    upd_evt = run && (cnt == top);
  end

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  // reads take one wait state so the data phase sees every
  // write that went just before it
  always_comb
  begin
    ap_next      = ap_reg;
    rd_wait_next = 1'b0;
    ready_next   = 1'b1;
    rdata_next   = rdata_reg;
    if (ready_reg)
    begin
      ap_next.wr   = hsel && htrans[1] && hready && hwrite;
      ap_next.rd   = hsel && htrans[1] && hready && !hwrite;
      ap_next.addr = haddr[7:0];
      if (ap_next.rd)
      begin
        rd_wait_next = 1'b1;
        ready_next   = 1'b0;
      end
    end
    if (rd_wait_reg)
    begin
      ap_next.rd = 1'b0;
      rdata_next = 32'h0000_0000;
      case (ap_reg.addr)
        // reserved bits held at zero
        tmc_pkg::ADDR_CTRL_A: rdata_next[7:0] = ctrl_a_reg;
        tmc_pkg::ADDR_CTRL_B: rdata_next[7:0] = ctrl_b_reg;
        tmc_pkg::ADDR_CMP_A:  rdata_next[7:0] = cmp_a_buf_reg;
        tmc_pkg::ADDR_CMP_B:  rdata_next[7:0] = cmp_b_buf_reg;
        tmc_pkg::ADDR_COUNT:  rdata_next[7:0] = cnt;
        tmc_pkg::ADDR_STATUS: rdata_next[2:0] = status_reg;
        tmc_pkg::ADDR_MASK:   rdata_next[2:0] = mask_reg;
        default:              rdata_next      = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_reg      <= '0;
      rd_wait_reg <= 1'b0;
      ready_reg   <= 1'b1;
      rdata_reg   <= 32'h0000_0000;
    end
    else
    begin
      ap_reg      <= ap_next;
      rd_wait_reg <= rd_wait_next;
      ready_reg   <= ready_next;
      rdata_reg   <= rdata_next;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_comb
  begin
    wr_a  = ap_reg.wr && ap_reg.addr == tmc_pkg::ADDR_CTRL_A;
    wr_b  = ap_reg.wr && ap_reg.addr == tmc_pkg::ADDR_CTRL_B;
    wr_ca = ap_reg.wr && ap_reg.addr == tmc_pkg::ADDR_CMP_A;
    wr_cb = ap_reg.wr && ap_reg.addr == tmc_pkg::ADDR_CMP_B;
    wr_st = ap_reg.wr && ap_reg.addr == tmc_pkg::ADDR_STATUS;
    wr_mk = ap_reg.wr && ap_reg.addr == tmc_pkg::ADDR_MASK;
    // reserved bits never stored: 3 and 2 of ctrl_a, all but 3 and 0 of ctrl_b
    ctrl_a_next = wr_a ? (hwdata[7:0] & tmc_pkg::CTRL_A_WMASK)
                       : ctrl_a_reg;
    ctrl_b_next = wr_b ? (hwdata[7:0] & tmc_pkg::CTRL_B_WMASK)
                       : ctrl_b_reg;
    cmp_a_buf_next = wr_ca ? hwdata[7:0] : cmp_a_buf_reg;
    cmp_b_buf_next = wr_cb ? hwdata[7:0] : cmp_b_buf_reg;
    // immediate in normal and clear-on-match
    if (!dbl_buf)
    begin
      cmp_a_act_next = cmp_a_buf_next;
      cmp_b_act_next = cmp_b_buf_next;
    end
    else if (upd_evt)
    begin
      cmp_a_act_next = cmp_a_buf_reg;
      cmp_b_act_next = cmp_b_buf_reg;
    end
    else
    begin
      cmp_a_act_next = cmp_a_act_reg;
      cmp_b_act_next = cmp_b_act_reg;
    end
    mask_next = wr_mk ? hwdata[2:0] : mask_reg;
  end

  // ------------------------------------------------------------
  // events and interrupt
  // ------------------------------------------------------------
  always_comb
  begin
    // overflow point per mode
    case (mode)
      tmc_pkg::MODE_PC_FF,
      tmc_pkg::MODE_PC_A:
        ovf_evt = run && !up && cnt == tmc_pkg::CNT_BOTTOM;
      tmc_pkg::MODE_FAST_A:
        ovf_evt = run && cnt == top;
      default:
        ovf_evt = run && cnt == tmc_pkg::CNT_MAX;
    endcase
    set_evt          = 3'h0;
    set_evt[tmc_pkg::ST_OVF] = ovf_evt;
    set_evt[tmc_pkg::ST_MA]  = run && cnt == cmp_a_act_reg;
    set_evt[tmc_pkg::ST_MB]  = run && cnt == cmp_b_act_reg;
    // a new event wins over a write-one clear
    status_next = (status_reg & ~(wr_st ? hwdata[2:0] : 3'h0))
                  | set_evt;
    irq_next    = |(status_next & mask_next);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_a_reg    <= tmc_pkg::CTRL_RST;
      ctrl_b_reg    <= tmc_pkg::CTRL_RST;
      cmp_a_buf_reg <= tmc_pkg::CMP_RST;
      cmp_b_buf_reg <= tmc_pkg::CMP_RST;
      cmp_a_act_reg <= tmc_pkg::CMP_RST;
      cmp_b_act_reg <= tmc_pkg::CMP_RST;
      status_reg    <= tmc_pkg::STAT_RST;
      mask_reg      <= tmc_pkg::STAT_RST;
      irq_reg       <= 1'b0;
    end
    else
    begin
      ctrl_a_reg    <= ctrl_a_next;
      ctrl_b_reg    <= ctrl_b_next;
      cmp_a_buf_reg <= cmp_a_buf_next;
      cmp_b_buf_reg <= cmp_b_buf_next;
      cmp_a_act_reg <= cmp_a_act_next;
      cmp_b_act_reg <= cmp_b_act_next;
      status_reg    <= status_next;
      mask_reg      <= mask_next;
      irq_reg       <= irq_next;
    end
  end

  // ------------------------------------------------------------
  // counter and channels
  // ------------------------------------------------------------
  tmc_counter u_counter (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (run),
    .mode    (mode),
    .top     (top),
    .cnt_reg (cnt),
    .up_reg  (up)
  );

  tmc_channel #(
    .PWM_TOGGLE_OK (1'b1)
  ) u_chan_a (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .tick        (run),
    .mode        (mode),
    .high_bit    (high_bit),
    .om          (tmc_pkg::tmc_om_e'(ctrl_a_reg[tmc_pkg::OM_A_POS +: 2])),
    .cnt         (cnt),
    .cmp         (cmp_a_act_reg),
    .top         (top),
    .up          (up),
    .wave_reg    (chan_a_out),
    .connect_reg (chan_a_connect)
  );

  // channel B 01 in pwm stays disconnected
  tmc_channel #(
    .PWM_TOGGLE_OK (1'b0)
  ) u_chan_b (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .tick        (run),
    .mode        (mode),
    .high_bit    (high_bit),
    .om          (tmc_pkg::tmc_om_e'(ctrl_a_reg[tmc_pkg::OM_B_POS +: 2])),
    .cnt         (cnt),
    .cmp         (cmp_b_act_reg),
    .top         (top),
    .up          (up),
    .wave_reg    (chan_b_out),
    .connect_reg (chan_b_connect)
  );

  assign hreadyout = ready_reg;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;
  assign irq       = irq_reg;

endmodule

// ==== tmc_pkg.sv ====
package tmc_pkg;

  // ------------------------------------------------------------
  // register byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_A = 8'h30;
  localparam logic [7:0] ADDR_CTRL_B = 8'h34;
  localparam logic [7:0] ADDR_CMP_A  = 8'h38;
  localparam logic [7:0] ADDR_CMP_B  = 8'h3c;
  localparam logic [7:0] ADDR_COUNT  = 8'h40;
  localparam logic [7:0] ADDR_STATUS = 8'h44;
  localparam logic [7:0] ADDR_MASK   = 8'h48;

  // ------------------------------------------------------------
  // field positions, masks and reset values
  // ------------------------------------------------------------
  localparam int         OM_A_POS     = 6;
  localparam int         OM_B_POS     = 4;
  localparam int         MODE_LO_POS  = 0;
  localparam int         HB_POS       = 3;
  localparam int         RUN_POS      = 0;
  localparam logic [7:0] CTRL_A_WMASK = 8'hf3;
  localparam logic [7:0] CTRL_B_WMASK = 8'h09;
  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam logic [7:0] CMP_RST      = 8'h00;
  localparam logic [2:0] STAT_RST     = 3'h0;
  localparam int         ST_OVF       = 0;
  localparam int         ST_MA        = 1;
  localparam int         ST_MB        = 2;
  localparam logic [7:0] CNT_MAX      = 8'hff;
  localparam logic [7:0] CNT_BOTTOM   = 8'h00;
  localparam logic [7:0] CNT_ONE      = 8'h01;

  // ------------------------------------------------------------
  // modes
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_NORMAL  = 3'h0,
    MODE_PC_FF   = 3'h1,
    MODE_CLR_TOP = 3'h2,
    MODE_FAST_FF = 3'h3,
    MODE_RSV4    = 3'h4,
    MODE_PC_A    = 3'h5,
    MODE_RSV6    = 3'h6,
    MODE_FAST_A  = 3'h7
  } tmc_mode_e;

  typedef enum logic [1:0] {
    OM_OFF    = 2'h0,
    OM_TOGGLE = 2'h1,
    OM_CLEAR  = 2'h2,
    OM_SET    = 2'h3
  } tmc_om_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
  } tmc_aphase_s;

  function automatic logic f_is_pc(input tmc_mode_e m);
    f_is_pc = (m == MODE_PC_FF) || (m == MODE_PC_A);
  endfunction

  function automatic logic f_is_fast(input tmc_mode_e m);
    f_is_fast = (m == MODE_FAST_FF) || (m == MODE_FAST_A);
  endfunction

  function automatic logic [7:0] f_top(input tmc_mode_e m,
                                       input logic [7:0] cmp_a);
    if (m == MODE_CLR_TOP || m == MODE_PC_A || m == MODE_FAST_A)
      f_top = cmp_a;
    else
      f_top = CNT_MAX;
  endfunction

endpackage

// ==== tmc_counter.sv ====
`timescale 1ns/1ps
module tmc_counter (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              run,
  input  wire tmc_pkg::tmc_mode_e mode,
  input  wire logic [7:0]        top,
  output logic      [7:0]        cnt_reg,
  output logic                   up_reg
);

  logic [7:0] cnt_next;
  logic       up_next;

  // ------------------------------------------------------------
  // counting sequence
  // ------------------------------------------------------------
  always_comb
  begin
    cnt_next = cnt_reg;
    up_next  = up_reg;
    if (run)
    begin
      if (tmc_pkg::f_is_pc(mode))
      begin
        // dual slope, top held for one tick
        if (top == tmc_pkg::CNT_BOTTOM)
          cnt_next = tmc_pkg::CNT_BOTTOM;
        else if (up_reg && cnt_reg == top)
        begin
          up_next  = 1'b0;
          cnt_next = cnt_reg - tmc_pkg::CNT_ONE;
        end
        else if (!up_reg && cnt_reg == tmc_pkg::CNT_BOTTOM)
        begin
          up_next  = 1'b1;
          cnt_next = tmc_pkg::CNT_ONE;
        end
        else if (up_reg)
          cnt_next = cnt_reg + tmc_pkg::CNT_ONE;
        else
          cnt_next = cnt_reg - tmc_pkg::CNT_ONE;
      end
      else
      begin
        up_next = 1'b1;
        // single slope, clear the tick after top
        if (cnt_reg == top)
          cnt_next = tmc_pkg::CNT_BOTTOM;
        else
          cnt_next = cnt_reg + tmc_pkg::CNT_ONE;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_reg <= tmc_pkg::CNT_BOTTOM;
      up_reg  <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_next;
      up_reg  <= up_next;
    end
  end

endmodule

// ==== tmc_channel.sv ====
`timescale 1ns/1ps
module tmc_channel #(
  parameter logic PWM_TOGGLE_OK = 1'b1
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              tick,
  input  wire tmc_pkg::tmc_mode_e mode,
  input  wire logic              high_bit,
  input  wire tmc_pkg::tmc_om_e  om,
  input  wire logic [7:0]        cnt,
  input  wire logic [7:0]        cmp,
  input  wire logic [7:0]        top,
  input  wire logic              up,
  output logic                   wave_reg,
  output logic                   connect_reg
);

  logic wave_next;
  logic connect_next;
  logic pwm;
  logic tog_ok;
  logic match;
  logic at_top;
  logic top_eq;
  logic rising;

  // ------------------------------------------------------------
  // waveform actions
  // ------------------------------------------------------------
  always_comb
  begin
    pwm    = tmc_pkg::f_is_pc(mode) || tmc_pkg::f_is_fast(mode);
    tog_ok = PWM_TOGGLE_OK && high_bit;
    match  = tick && (cnt == cmp);
    at_top = tick && (cnt == top);
    top_eq = om[1] && (cmp == top);
    // bottom belongs to the up slope, so a zero compare stays flat
    rising = up || (cnt == tmc_pkg::CNT_BOTTOM);
    wave_next = wave_reg;
    if (!pwm)
    begin
      if (match)
      begin
        case (om)
          tmc_pkg::OM_TOGGLE: wave_next = !wave_reg;
          tmc_pkg::OM_CLEAR:  wave_next = 1'b0;
          tmc_pkg::OM_SET:    wave_next = 1'b1;
          default:            wave_next = wave_reg;
        endcase
      end
    end
    else if (tmc_pkg::f_is_fast(mode))
    begin
      if (match && !top_eq)
      begin
        case (om)
          tmc_pkg::OM_TOGGLE: wave_next = tog_ok ? !wave_reg : wave_reg;
          tmc_pkg::OM_CLEAR:  wave_next = 1'b0;
          tmc_pkg::OM_SET:    wave_next = 1'b1;
          default:            wave_next = wave_reg;
        endcase
      end
      // top to bottom step; matches at top ignored in clear and set
      if (at_top && om[1])
        wave_next = (om == tmc_pkg::OM_CLEAR);
    end
    else
    begin
      if (match && !top_eq)
      begin
        case (om)
          tmc_pkg::OM_TOGGLE: wave_next = tog_ok ? !wave_reg : wave_reg;
          tmc_pkg::OM_CLEAR:  wave_next = !rising;
          tmc_pkg::OM_SET:    wave_next = rising;
          default:            wave_next = wave_reg;
        endcase
      end
      // down-count level taken at top instead
      if (at_top && top_eq)
        wave_next = (om == tmc_pkg::OM_CLEAR);
    end
    // 01 in pwm is off unless toggle allowed
    connect_next = (om != tmc_pkg::OM_OFF) &&
                   !(pwm && om == tmc_pkg::OM_TOGGLE && !tog_ok);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wave_reg    <= 1'b0;
      connect_reg <= 1'b0;
    end
    else
    begin
      wave_reg    <= wave_next;
      connect_reg <= connect_next;
    end
  end

endmodule

// ==== tmc_timer_sva.sv ====
`timescale 1ns/1ps
module tmc_timer_sva (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        irq,
  input wire logic        chan_a_connect,
  input wire logic        chan_b_connect
);
  // ----------------------------------------
  // bus tracking and mode shadow
  // ----------------------------------------
  logic       take, wr_dp, rd_dp, wr_done, rd_done, hb, exp_a, exp_b;
  logic [7:0] dp_addr, sa;
  logic [1:0] settle;
  assign take    = hsel && htrans[1] && hready;
  assign wr_done = wr_dp && hready;
  assign rd_done = rd_dp && hready;
  // odd modes are the pwm ones
  assign exp_a = sa[7:6] != 2'h0 && !(sa[0] && sa[7:6] == 2'h1 && !hb);
  assign exp_b = sa[5:4] != 2'h0 && !(sa[0] && sa[5:4] == 2'h1);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_dp   <= 1'b0;
      rd_dp   <= 1'b0;
      dp_addr <= 8'h00;
      sa      <= 8'h00;
      hb      <= 1'b0;
      settle  <= 2'h0;
    end
    else
    begin
      if (hready)
      begin
        wr_dp   <= take && hwrite;
        rd_dp   <= take && !hwrite;
        dp_addr <= haddr[7:0];
      end
      if (wr_done && dp_addr == tmc_pkg::ADDR_CTRL_A)
        sa <= hwdata[7:0];
      if (wr_done && dp_addr == tmc_pkg::ADDR_CTRL_B)
        hb <= hwdata[tmc_pkg::HB_POS];
      // connect is registered, so judge it only once writes settle
      if (wr_done)
        settle <= 2'h0;
      else if (settle != 2'h3)
        settle <= settle + 2'h1;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd_req;
    take && !hwrite;
  endsequence
  sequence s_rd_ans;
    !hreadyout ##1 hreadyout;
  endsequence
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  read_wait_a: assert property (s_rd_req |=> s_rd_ans)
    else $error("read wait state wrong");
  write_fast_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  wait_single_a: assert property (!hreadyout |=> hreadyout)
    else $error("wait state too long");
  upper_zero_a: assert property (rd_done |-> hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  rsv_zero_a: assert property (
    rd_done && dp_addr == tmc_pkg::ADDR_CTRL_A |-> hrdata[3:2] == 2'h0)
    else $error("reserved control bits read set");
  irq_fall_a: assert property (
    $fell(irq) |-> $past(wr_done) || $past(wr_done, 2))
    else $error("irq dropped without a write");
  conn_a_a: assert property (
    settle == 2'h3 |-> chan_a_connect == exp_a)
    else $error("channel a connect wrong");
  conn_b_a: assert property (
    settle == 2'h3 |-> chan_b_connect == exp_b)
    else $error("channel b connect wrong");
endmodule
bind tmc_timer tmc_timer_sva u_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
  .chan_a_connect(chan_a_connect), .chan_b_connect(chan_b_connect));

// ==== tmc_pin_model.sv ====
`timescale 1ns/1ps
module tmc_pin_model (
  input  wire logic dir_out,
  input  wire logic connect,
  input  wire logic wave,
  input  wire logic port_val,
  output logic      pin
);
  // driver off leaves the line to its pull-up
  assign pin = !dir_out ? 1'b1 : (connect ? wave : port_val);
endmodule

// ==== tmc_timer_tb.sv ====
`timescale 1ns/1ps
module tmc_timer_tb;
  logic        hclk, hresetn, hsel, hwrite, dir_out, hreadyout, hresp, irq;
  logic        pin_a, pin_b, a_out, a_con, b_out, b_con, hb;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [7:0]  v;
  int          err_count, checks, seed, hi, per, n;
  logic [7:0]  t_ca [9] = '{8'h42, 8'h43, 8'h41, 8'h23, 8'h33, 8'h21,
                            8'h40, 8'hc1, 8'h12};
  logic [7:0]  t_a [9] = '{9, 9, 6, 16, 16, 16, 16, 128, 9};
  logic [7:0]  t_b [9] = '{0, 0, 0, 63, 63, 128, 0, 0, 3};
  bit          t_hb [9] = '{0, 1, 1, 0, 0, 0, 0, 0, 0};
  bit          t_ch [9] = '{0, 0, 0, 1, 1, 1, 0, 0, 1};
  int          t_hi [9] = '{10, 10, 12, 64, 192, 256, 256, 254, 10};
  int          t_per [9] = '{20, 20, 24, 256, 256, 510, 512, 510, 20};
  logic [7:0]  rst_addr [8] = '{8'h30, 8'h34, 8'h38, 8'h3c, 8'h40, 8'h44,
                                8'h48, 8'h4c};

  tmc_timer u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .irq(irq), .chan_a_out(a_out), .chan_a_connect(a_con),
    .chan_b_out(b_out), .chan_b_connect(b_con));
  tmc_pin_model u_pin_a (.dir_out(dir_out), .connect(a_con), .wave(a_out),
                         .port_val(1'b0), .pin(pin_a));
  tmc_pin_model u_pin_b (.dir_out(dir_out), .connect(b_con), .wave(b_out),
                         .port_val(1'b0), .pin(pin_b));

  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic report_and_stop;
    $display("mismatches %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wait_rdy;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
  endtask
  function automatic logic pin(input bit ch);
    pin = ch ? pin_b : pin_a;
  endfunction
  function automatic logic exp_a(input logic [7:0] c, input logic h);
    exp_a = c[7:6] != 2'h0 && !(c[0] && c[7:6] == 2'h1 && !h);
  endfunction
  task automatic wait_lvl(input bit ch, input logic l);
    int k;
    k = 0;
    while (pin(ch) !== l && k < 2000)
    begin
      @(posedge hclk);
      k++;
    end
    if (k >= 2000)
      err_count++;
  endtask
  task automatic measure(input bit ch);
    wait_lvl(ch, 1'b0);
    wait_lvl(ch, 1'b1);
    hi = 0;
    per = 0;
    while (pin(ch) === 1'b1 && per < 2000)
    begin
      @(posedge hclk);
      hi++;
      per++;
    end
    while (pin(ch) === 1'b0 && per < 2000)
    begin
      @(posedge hclk);
      per++;
    end
  endtask
  task automatic cfg(input logic [7:0] ca, input logic h,
                     input logic [7:0] a, input logic [7:0] b);
    bus(tmc_pkg::ADDR_CTRL_B, 1'b1, 32'h0);
    bus(tmc_pkg::ADDR_CMP_A, 1'b1, {24'h0, a});
    bus(tmc_pkg::ADDR_CMP_B, 1'b1, {24'h0, b});
    bus(tmc_pkg::ADDR_CTRL_A, 1'b1, {24'h0, ca});
    bus(tmc_pkg::ADDR_CTRL_B, 1'b1, {28'h0, h, 3'h1});
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    seed = 15677;
    err_count = 0;
    checks = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    dir_out = 1'b1;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (rst_addr[i])
    begin
      bus(rst_addr[i], 1'b0, 32'h0);
      chk("reset value", 32'h0, q);
    end
    for (int i = 0; i < 12; i++)
    begin
      v = (i < 2) ? 8'h51 : 8'($random(seed));
      hb = i[0];
      bus(tmc_pkg::ADDR_CTRL_B, 1'b1, {28'h0, hb, 3'h0});
      bus(tmc_pkg::ADDR_CTRL_A, 1'b1, {24'h0, v});
      repeat (3) @(posedge hclk);
      chk("con_a", {31'h0, exp_a(v, hb)}, {31'h0, a_con});
      chk("con_b", {31'h0, v[5:4] != 0 && !(v[0] && v[5:4] == 1)},
          {31'h0, b_con});
      bus(tmc_pkg::ADDR_CTRL_A, 1'b0, 32'h0);
      chk("ctrl_a", {24'h0, v & 8'hf3}, q);
    end
    bus(tmc_pkg::ADDR_CTRL_B, 1'b1, 32'hff);
    bus(tmc_pkg::ADDR_CTRL_B, 1'b0, 32'h0);
    chk("ctrl_b", 32'h9, q);
    foreach (t_ca[i])
    begin
      cfg(t_ca[i], t_hb[i], t_a[i], t_b[i]);
      measure(t_ch[i]);
      measure(t_ch[i]);
      chk("high time", t_hi[i], hi);
      chk("period", t_per[i], per);
    end
    for (int i = 0; i < 2; i++)
    begin
      // compare at top: output must sit high
      cfg(i ? 8'h81 : 8'h83, 1'b0, 8'hff, 8'h00);
      repeat (600) @(posedge hclk);
      n = 0;
      repeat (520)
      begin
        @(posedge hclk);
        n += (pin_a !== 1'b1);
      end
      chk("flat output", 0, n);
    end
    dir_out <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("pulled pin", 1, pin_b);
    cfg(8'h00, 1'b0, 8'h10, 8'h10);
    bus(tmc_pkg::ADDR_MASK, 1'b1, 32'h0);
    bus(tmc_pkg::ADDR_STATUS, 1'b1, 32'h7);
    repeat (300) @(posedge hclk);
    chk("masked irq", 0, irq);
    bus(tmc_pkg::ADDR_CTRL_B, 1'b1, 32'h0);
    bus(tmc_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk("overflow at max", 1, q[0]);
    bus(tmc_pkg::ADDR_MASK, 1'b1, 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq raised", 1, irq);
    bus(tmc_pkg::ADDR_STATUS, 1'b1, 32'h7);
    repeat (2) @(posedge hclk);
    chk("irq cleared", 0, irq);
    bus(tmc_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk("status cleared", 0, q);
    cfg(8'h43, 1'b1, 8'h09, 8'h00);
    repeat (300) @(posedge hclk);
    bus(tmc_pkg::ADDR_STATUS, 1'b1, 32'h7);
    repeat (20) @(posedge hclk);
    chk("overflow at top", 1, irq);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(tmc_pkg::ADDR_CTRL_A, 1'b0, 32'h0);
    chk("ctrl_a after reset", 0, q);
    chk("con_a after reset", 0, a_con);
    report_and_stop;
  end
  initial
  begin
    #400000;
    err_count++;
    report_and_stop;
  end
endmodule
